/* File: hdl/slk_defs.vh */
`ifndef SLK_DEFS_VH
`define SLK_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SLK_ADDR_W            12
`define SLK_DATA_W            8
`define SLK_ADDR_MODE         12'h201
`define SLK_ADDR_KM1          12'h202
`define SLK_ADDR_SYNC         12'h203
`define SLK_ADDR_CTRL         12'h204
`define SLK_ADDR_STATUS       12'h20F

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define SLK_MODE_MSB          5
`define SLK_MODE_W            6
`define SLK_KM1_W             8
`define SLK_SYNC_BIT          0
`define SLK_CTRL_SCR_BIT      0
`define SLK_CTRL_FMT_BIT      1
`define SLK_CTRL_SEL_LSB      2
`define SLK_CTRL_SEL_MSB      3
`define SLK_CTRL_LANE_BIT     4
`define SLK_STAT_REQ_BIT      0
`define SLK_STAT_66_BIT       1
`define SLK_STAT_EN_BIT       2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SLK_RST_MODE          6'h00
`define SLK_RST_KM1           8'h1F
`define SLK_RST_SYNC_N        1'h1
`define SLK_RST_SCR           1'h1
`define SLK_RST_FMT           1'h1
`define SLK_RST_SEL           2'h0
`define SLK_RST_LANE          1'h0

// ----------------------------------------------------------------------------
// Sync sources, lanes and multiframe arithmetic
// ----------------------------------------------------------------------------
`define SLK_SEL_DEDICATED     2'h0
`define SLK_SEL_TIMESTAMP     2'h1
`define SLK_SEL_NONE          2'h2
`define SLK_NUM_LANES         8
`define SLK_LANE_CNT_W        4
`define SLK_UPPER_LANE_BASE   4
`define SLK_EF_W              8
`define SLK_K_W               16
`define SLK_K_PER_E           16'h0100
`define SLK_SYNC_PINS         2
`define SLK_PIN_DEDICATED     0
`define SLK_PIN_TIMESTAMP     1

`endif

/* File: hdl/slk_pin_sync.v */
`timescale 1ns/1ps
`include "slk_defs.vh"
module slk_pin_sync (
    // Clock and reset
    input  wire                       clk_sys_i,
    input  wire                       rst_n_i,
    input  wire                       ce_i,
    // Pins and synchronised levels
    input  wire [`SLK_SYNC_PINS-1:0]  pin_i,
    output wire [`SLK_SYNC_PINS-1:0]  level_o
);

// ----------------------------------------------------------------------------
// Two-stage synchronisers
// ----------------------------------------------------------------------------
// Pins idle high, so reset to high to avoid a false request at release.
genvar g;
generate
    for (g = 0; g < `SLK_SYNC_PINS; g = g + 1) begin : g_sync
        reg meta_q;
        reg sync_q;
        always @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                meta_q <= 1'b1;
                sync_q <= 1'b1;
            end else if (ce_i) begin
                meta_q <= pin_i[g];
                sync_q <= meta_q;
            end
        end
        assign level_o[g] = sync_q;
    end
endgenerate

endmodule // slk_pin_sync

/* File: hdl/slk_link_cfg.v */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "slk_defs.vh"
module slk_link_cfg (
    // Clock, reset and clock enable
    input  wire                         clk_sys_i,
    input  wire                         rst_n_i,
    input  wire                         ce_i,
    // Register port
    input  wire [`SLK_ADDR_W-1:0]       reg_addr_i,
    input  wire [`SLK_DATA_W-1:0]       reg_wdata_i,
    input  wire                         reg_wr_i,
    input  wire                         reg_rd_i,
    output reg  [`SLK_DATA_W-1:0]       reg_rdata_o,
    // Interlocks from the enable registers
    input  wire                         link_enable_i,
    input  wire                         cal_enable_i,
    input  wire                         timestamp_receiver_enable_i,
    // Attributes of the selected mode from the mode table
    input  wire                         mode_is_64b66b_i,
    input  wire [`SLK_LANE_CNT_W-1:0]   mode_lanes_i,
    input  wire [`SLK_EF_W-1:0]         mode_e_i,
    input  wire [`SLK_EF_W-1:0]         mode_f_i,
    // Sync pins, active low
    input  wire                         dedicated_sync_input_n_i,
    input  wire                         timestamp_input_n_i,
    // Link configuration
    output reg  [`SLK_MODE_W-1:0]       link_mode_code_o,
    output reg  [`SLK_K_W-1:0]          eff_k_o,
    output reg                          sync_request_n_o,
    output reg  [`SLK_NUM_LANES-1:0]    lane_enable_o,
    output reg                          sample_coding_o,
    output reg                          scrambler_active_o,
    // Link power and reset
    output reg                          link_reset_n_o,
    output reg                          serializer_power_down_o,
    output reg                          link_clock_en_o,
    // Interlock warning, set on a mode, KM1 or control write made while the link may be running
    output reg                          cfg_write_unsafe_o
);

// ----------------------------------------------------------------------------
// Register state
// ----------------------------------------------------------------------------
reg  [`SLK_MODE_W-1:0]      link_mode_code_q;
reg  [`SLK_KM1_W-1:0]       multiframe_len_m1_q;
reg                         soft_sync_request_n_q;
reg                         upper_lane_map_q;
reg  [1:0]                  sync_source_q;
reg                         sample_coding_q;
reg                         scrambler_on_q;

wire [`SLK_SYNC_PINS-1:0]   pin_raw;
wire [`SLK_SYNC_PINS-1:0]   pin_sync;
wire                        wr_mode;
wire                        wr_km1;
wire                        wr_sync;
wire                        wr_ctrl;

assign pin_raw[`SLK_PIN_DEDICATED] = dedicated_sync_input_n_i;
assign pin_raw[`SLK_PIN_TIMESTAMP] = timestamp_input_n_i;

assign wr_mode = reg_wr_i && (reg_addr_i == `SLK_ADDR_MODE);
assign wr_km1  = reg_wr_i && (reg_addr_i == `SLK_ADDR_KM1);
assign wr_sync = reg_wr_i && (reg_addr_i == `SLK_ADDR_SYNC);
assign wr_ctrl = reg_wr_i && (reg_addr_i == `SLK_ADDR_CTRL);

slk_pin_sync u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .pin_i     (pin_raw),
    .level_o   (pin_sync)
);

// ----------------------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------------------
// Reserved bits are not stored; they always read back as zero.
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        link_mode_code_q      <= `SLK_RST_MODE;
        multiframe_len_m1_q   <= `SLK_RST_KM1;
        soft_sync_request_n_q <= `SLK_RST_SYNC_N;
        upper_lane_map_q      <= `SLK_RST_LANE;
        sync_source_q         <= `SLK_RST_SEL;
        sample_coding_q       <= `SLK_RST_FMT;
        scrambler_on_q        <= `SLK_RST_SCR;
    end else if (ce_i) begin
        if (wr_mode) begin
            link_mode_code_q <= reg_wdata_i[`SLK_MODE_MSB:0];
        end
        if (wr_km1) begin
            multiframe_len_m1_q <= reg_wdata_i;
        end
        if (wr_sync) begin
            soft_sync_request_n_q <= reg_wdata_i[`SLK_SYNC_BIT];
        end
        if (wr_ctrl) begin
            scrambler_on_q   <= reg_wdata_i[`SLK_CTRL_SCR_BIT];
            sample_coding_q  <= reg_wdata_i[`SLK_CTRL_FMT_BIT];
            sync_source_q    <= reg_wdata_i[`SLK_CTRL_SEL_MSB:`SLK_CTRL_SEL_LSB];
            upper_lane_map_q <= reg_wdata_i[`SLK_CTRL_LANE_BIT];
        end
    end
end

// ----------------------------------------------------------------------------
// Read port
// ----------------------------------------------------------------------------
reg [`SLK_DATA_W-1:0] rd_mux;

always @* begin
    rd_mux = {`SLK_DATA_W{1'b0}};
    case (reg_addr_i)
        `SLK_ADDR_MODE: begin
            rd_mux[`SLK_MODE_MSB:0] = link_mode_code_q;
        end
        `SLK_ADDR_KM1: begin
            rd_mux = multiframe_len_m1_q;
        end
        `SLK_ADDR_SYNC: begin
            rd_mux[`SLK_SYNC_BIT] = soft_sync_request_n_q;
        end
        `SLK_ADDR_CTRL: begin
            rd_mux[`SLK_CTRL_SCR_BIT]                     = scrambler_on_q;
            rd_mux[`SLK_CTRL_FMT_BIT]                     = sample_coding_q;
            rd_mux[`SLK_CTRL_SEL_MSB:`SLK_CTRL_SEL_LSB]   = sync_source_q;
            rd_mux[`SLK_CTRL_LANE_BIT]                    = upper_lane_map_q;
        end
        `SLK_ADDR_STATUS: begin
            rd_mux[`SLK_STAT_REQ_BIT] = sync_request_n_o;
            rd_mux[`SLK_STAT_66_BIT]  = mode_is_64b66b_i;
            rd_mux[`SLK_STAT_EN_BIT]  = link_enable_i;
        end
        default: begin
            rd_mux = {`SLK_DATA_W{1'b0}};
        end
    endcase
end

// Read data stand for exactly the cycle after the strobe, zero otherwise.
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        reg_rdata_o <= {`SLK_DATA_W{1'b0}};
    end else if (ce_i) begin
        reg_rdata_o <= reg_rd_i ? rd_mux : {`SLK_DATA_W{1'b0}};
    end
end

// ----------------------------------------------------------------------------
// Multiframe length
// ----------------------------------------------------------------------------
// The divider is combinational; the mode only changes with the link down,
// so its settling time does not matter in practice.
reg  [`SLK_K_W-1:0] k_d;
wire [`SLK_K_W-1:0] e_scaled;
wire [`SLK_K_W-1:0] f_wide;

assign e_scaled = {mode_e_i, {(`SLK_K_W-`SLK_EF_W){1'b0}}};
assign f_wide   = {{(`SLK_K_W-`SLK_EF_W){1'b0}}, mode_f_i};

always @* begin
    k_d = {`SLK_K_W{1'b0}};
    if (mode_is_64b66b_i) begin
        if (f_wide != {`SLK_K_W{1'b0}}) begin
            k_d = e_scaled / f_wide;
        end
    end else begin
        k_d = {{(`SLK_K_W-`SLK_KM1_W){1'b0}}, multiframe_len_m1_q}
              + {{(`SLK_K_W-1){1'b0}}, 1'b1};
    end
end

// ----------------------------------------------------------------------------
// Sync request
// ----------------------------------------------------------------------------
// Selecting the timestamp input without its receiver enabled gives no request
// from that pin; code 3 is treated like code 2.
reg pin_req_n;

always @* begin
    pin_req_n = 1'b1;
    case (sync_source_q)
        `SLK_SEL_DEDICATED: begin
            pin_req_n = pin_sync[`SLK_PIN_DEDICATED];
        end
        `SLK_SEL_TIMESTAMP: begin
            pin_req_n = pin_sync[`SLK_PIN_TIMESTAMP] | ~timestamp_receiver_enable_i;
        end
        `SLK_SEL_NONE: begin
            pin_req_n = 1'b1;
        end
        default: begin
            pin_req_n = 1'b1;
        end
    endcase
end

// ----------------------------------------------------------------------------
// Lane mapping
// ----------------------------------------------------------------------------
// Upper mapping with more than four lanes is undefined; lanes past the top
// simply stay off.
wire [`SLK_NUM_LANES-1:0] lane_d;

genvar ln;
generate
    for (ln = 0; ln < `SLK_NUM_LANES; ln = ln + 1) begin : g_lane
        localparam [`SLK_LANE_CNT_W-1:0] IDX  = ln;
        localparam [`SLK_LANE_CNT_W-1:0] BASE = `SLK_UPPER_LANE_BASE;
        wire in_low;
        wire in_up;
        assign in_low = (IDX < mode_lanes_i);
        assign in_up  = (IDX >= BASE) && ((IDX - BASE) < mode_lanes_i);
        assign lane_d[ln] = link_enable_i && (upper_lane_map_q ? in_up : in_low);
    end
endgenerate

// ----------------------------------------------------------------------------
// Registered outputs
// ----------------------------------------------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        link_mode_code_o        <= `SLK_RST_MODE;
        eff_k_o                 <= {`SLK_K_W{1'b0}};
        sync_request_n_o        <= 1'b1;
        lane_enable_o           <= {`SLK_NUM_LANES{1'b0}};
        sample_coding_o         <= `SLK_RST_FMT;
        scrambler_active_o      <= `SLK_RST_SCR;
        link_reset_n_o          <= 1'b0;
        serializer_power_down_o <= 1'b1;
        link_clock_en_o         <= 1'b0;
        cfg_write_unsafe_o      <= 1'b0;
    end else if (ce_i) begin
        link_mode_code_o        <= link_mode_code_q;
        eff_k_o                 <= k_d;
        sync_request_n_o        <= soft_sync_request_n_q & pin_req_n;
        lane_enable_o           <= lane_d;
        sample_coding_o         <= sample_coding_q;
        scrambler_active_o      <= mode_is_64b66b_i | scrambler_on_q;
        link_reset_n_o          <= link_enable_i;
        serializer_power_down_o <= ~link_enable_i;
        link_clock_en_o         <= link_enable_i;
        // Sticky until reset; software relies on the interlocks, this only flags.
        if ((wr_mode && (link_enable_i || cal_enable_i))
            || ((wr_km1 || wr_ctrl || wr_sync) && link_enable_i && !wr_sync)) begin
            cfg_write_unsafe_o <= 1'b1;
        end
    end
end

endmodule // slk_link_cfg

/* File: sim/slk_rx_model.sv */
`timescale 1ns/1ps
module slk_rx_model (
    // Clock, reset and link state
    input  wire       clk_sys_i,
    input  wire       rst_n_i,
    input  wire       link_up_i,
    // Commands: hold a sync pin low on purpose
    input  wire [1:0] hold_low_i,
    // Sync pins, active low
    output wire       dedicated_sync_input_n_o,
    output wire       timestamp_input_n_o
);
    // The receiver requests sync until it has seen the link up for seven cycles.
    reg [2:0] up_cnt_q;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) up_cnt_q <= 3'h0;
        else if (!link_up_i) up_cnt_q <= 3'h0;
        else if (up_cnt_q != 3'h7) up_cnt_q <= up_cnt_q + 3'h1;
    end
    assign dedicated_sync_input_n_o = (up_cnt_q == 3'h7) && !hold_low_i[0];
    assign timestamp_input_n_o      = !hold_low_i[1];
endmodule // slk_rx_model

/* File: sim/slk_link_cfg_sva.sv */
`timescale 1ns/1ps
module slk_link_cfg_sva (
    // Clock, reset and register port
    input wire        clk_sys_i,
    input wire        rst_n_i,
    input wire        ce_i,
    input wire [11:0] reg_addr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_rdata_o,
    // Interlocks, mode attributes and pin
    input wire        link_enable_i,
    input wire        cal_enable_i,
    input wire        mode_is_64b66b_i,
    input wire [3:0]  mode_lanes_i,
    input wire [7:0]  mode_e_i,
    input wire [7:0]  mode_f_i,
    input wire        dedicated_sync_input_n_i,
    // Outputs
    input wire [5:0]  link_mode_code_o,
    input wire [15:0] eff_k_o,
    input wire        sync_request_n_o,
    input wire [7:0]  lane_enable_o,
    input wire        sample_coding_o,
    input wire        scrambler_active_o,
    input wire        link_reset_n_o,
    input wire        serializer_power_down_o,
    input wire        link_clock_en_o,
    input wire        cfg_write_unsafe_o
);
    // ------------------------------------------------------------------------
    // Register mirror
    // ------------------------------------------------------------------------
    reg  [7:0] mode_q, km1_q, soft_q, ctrl_q;
    wire       wr_w   = ce_i && reg_wr_i;
    wire [7:0] rexp_w = reg_addr_i == 12'h201 ? mode_q : reg_addr_i == 12'h202 ? km1_q :
                        reg_addr_i == 12'h203 ? soft_q : reg_addr_i == 12'h204 ? ctrl_q : 8'h00;
    function automatic [7:0] lmask(input [3:0] l, input up);
        lmask = 8'(((32'h1 << l) - 32'h1) << (up ? 4 : 0));
    endfunction
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= 8'h00;
            km1_q  <= 8'h1F;
            soft_q <= 8'h01;
            ctrl_q <= 8'h03;
        end else if (wr_w) begin
            if (reg_addr_i == 12'h201) mode_q <= reg_wdata_i & 8'h3F;
            if (reg_addr_i == 12'h202) km1_q <= reg_wdata_i;
            if (reg_addr_i == 12'h203) soft_q <= reg_wdata_i & 8'h01;
            if (reg_addr_i == 12'h204) ctrl_q <= reg_wdata_i & 8'h1F;
        end
    end
    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    AST_READ: assert property (ce_i && reg_rd_i && reg_addr_i != 12'h20F
        |=> reg_rdata_o == $past(rexp_w)) else $error("read data differs from register");
    AST_RD_IDLE: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read");
    AST_MODE: assert property (ce_i |=> link_mode_code_o == $past(mode_q[5:0]))
        else $error("mode code output wrong");
    AST_K: assert property (ce_i && mode_f_i != 8'h00 |=> eff_k_o ==
        ($past(mode_is_64b66b_i) ? {$past(mode_e_i), 8'h00} / $past(mode_f_i)
        : $past(km1_q) + 16'h1)) else $error("effective K wrong");
    AST_SOFT: assert property (wr_w && reg_addr_i == 12'h203 && !reg_wdata_i[0]
        |-> ##2 !sync_request_n_o) else $error("soft sync request not raised");
    AST_NOPIN: assert property (ce_i && ctrl_q[3] |=> sync_request_n_o == $past(soft_q[0]))
        else $error("pin not ignored with no source");
    AST_PIN: assert property ((ctrl_q[3:2] == 2'h0 && !dedicated_sync_input_n_i)[*3]
        |=> !sync_request_n_o) else $error("dedicated pin request lost");
    AST_LANES: assert property (ce_i && link_enable_i
        |=> lane_enable_o == lmask($past(mode_lanes_i), $past(ctrl_q[4])))
        else $error("lane enables wrong");
    AST_FMT: assert property (ce_i |=> sample_coding_o == $past(ctrl_q[1]))
        else $error("sample coding wrong");
    AST_SCR: assert property (ce_i
        |=> scrambler_active_o == ($past(mode_is_64b66b_i) || $past(ctrl_q[0])))
        else $error("scrambler state wrong");
    AST_OFF: assert property (ce_i && !link_enable_i |=> !link_reset_n_o &&
        serializer_power_down_o && !link_clock_en_o && lane_enable_o == 8'h00)
        else $error("link not held off while disabled");
    AST_UNSAFE: assert property (wr_w && (reg_addr_i == 12'h201 && (link_enable_i ||
        cal_enable_i) || (reg_addr_i == 12'h202 || reg_addr_i == 12'h204) && link_enable_i)
        |=> cfg_write_unsafe_o) else $error("unsafe write not flagged");
    COV_SOFT: cover property (wr_w && reg_addr_i == 12'h203 && !reg_wdata_i[0]);
    COV_K66: cover property (mode_is_64b66b_i && link_enable_i);
    COV_UPPER: cover property (ctrl_q[4] && link_enable_i);
endmodule // slk_link_cfg_sva
bind slk_link_cfg slk_link_cfg_sva u_sva (.*);

/* File: sim/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb;
    // ------------------------------------------------------------------------
    // Stimulus, observation and bookkeeping
    // ------------------------------------------------------------------------
    reg         clk_sys_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
    reg  [11:0] reg_addr_i = 12'h000;
    reg  [7:0]  reg_wdata_i = 8'h00, mode_e_i = 8'h01, mode_f_i = 8'h01;
    reg         reg_wr_i = 1'b0, reg_rd_i = 1'b0, link_enable_i = 1'b0, cal_enable_i = 1'b0;
    reg         timestamp_receiver_enable_i = 1'b0, mode_is_64b66b_i = 1'b0;
    reg  [3:0]  mode_lanes_i = 4'h2;
    reg  [1:0]  hold_q = 2'h0;
    wire        dedicated_sync_input_n_i, timestamp_input_n_i, sync_request_n_o;
    wire [7:0]  reg_rdata_o, lane_enable_o;
    wire [5:0]  link_mode_code_o;
    wire [15:0] eff_k_o;
    wire        sample_coding_o, scrambler_active_o, link_reset_n_o;
    wire        serializer_power_down_o, link_clock_en_o, cfg_write_unsafe_o;
    integer     bad_count = 0, comparisons = 0, seed = 68884, cyc = 0, i;
    reg  [7:0]  m, k, c;
    slk_link_cfg dut (.*);
    slk_rx_model u_rx (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link_up_i(link_clock_en_o),
        .hold_low_i(hold_q), .dedicated_sync_input_n_o(dedicated_sync_input_n_i),
        .timestamp_input_n_o(timestamp_input_n_i));
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim;
        end
    end
    function [15:0] exp_k(input h, input [7:0] e, input [7:0] f, input [7:0] km);
        exp_k = h ? (f == 8'h00 ? 16'h0000 : {e, 8'h00} / f) : km + 16'h1;
    endfunction
    function [7:0] exp_ln(input [3:0] l, input up);
        exp_ln = 8'(((32'h1 << l) - 32'h1) << (up ? 4 : 0));
    endfunction
    task step(input integer n); repeat (n) @(posedge clk_sys_i); endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_wr_i <= 1'b1;
            step(1);
            reg_wr_i <= 1'b0;
            step(1);
        end
    endtask
    task rd(input [11:0] a, input [7:0] e);
        begin
            reg_addr_i <= a;
            reg_rd_i <= 1'b1;
            step(1);
            reg_rd_i <= 1'b0;
            #1 `CHK("rdata", e, reg_rdata_o)
            step(1);
        end
    endtask
    // cfg writes configuration with the link and calibration off, then turns both on.
    task cfg(input [7:0] md, input [7:0] km, input [7:0] ct);
        begin
            link_enable_i <= 1'b0;
            cal_enable_i <= 1'b0;
            wr(12'h201, md);
            wr(12'h202, km);
            wr(12'h204, ct);
            link_enable_i <= 1'b1;
            cal_enable_i <= 1'b1;
            step(12);
            #1;
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        step(8);
        rst_n_i <= 1'b1;
        step(2);
        #1 `CHK("k_rst", 16'h0020, eff_k_o)
        `CHK("fmt_scr", 2'h3, {sample_coding_o, scrambler_active_o})
        `CHK("off", 4'h5, {link_reset_n_o, serializer_power_down_o, link_clock_en_o, lane_enable_o == 8'h00})
        rd(12'h201, 8'h00);
        rd(12'h202, 8'h1F);
        rd(12'h203, 8'h01);
        rd(12'h204, 8'h03);
        rd(12'h2FF, 8'h00);
        for (i = 0; i < 24; i++) begin
            m = $random(seed) & 8'h3F;
            k = (i == 0) ? 8'hFF : $random(seed);
            c = $random(seed) & 8'h17;
            mode_is_64b66b_i <= i[0];
            mode_lanes_i <= c[4] ? 4'h4 - i[1:0] : 4'h8 - i[1:0];
            mode_e_i <= $random(seed);
            mode_f_i <= 8'h01 + i;
            cfg(m, k, c);
            `CHK("mode", m[5:0], link_mode_code_o)
            `CHK("k", exp_k(i[0], mode_e_i, mode_f_i, k), eff_k_o)
            `CHK("scr", i[0] | c[0], scrambler_active_o)
            `CHK("fmt", c[1], sample_coding_o)
            `CHK("lanes", exp_ln(mode_lanes_i, c[4]), lane_enable_o)
            `CHK("on", 3'h5, {link_reset_n_o, serializer_power_down_o, link_clock_en_o})
            rd(12'h202, k);
        end
        cfg(8'h00, 8'h1F, 8'h03);
        `CHK("sync_up", 1'b1, sync_request_n_o)
        hold_q <= 2'h1;
        wr(12'h203, 8'h01);
        step(2);
        #1 `CHK("stuck", 1'b0, sync_request_n_o)
        cfg(8'h00, 8'h1F, 8'h0B);
        `CHK("nopin", 1'b1, sync_request_n_o)
        wr(12'h203, 8'h00);
        #1 `CHK("soft", 1'b0, sync_request_n_o)
        wr(12'h203, 8'h01);
        hold_q <= 2'h2;
        cfg(8'h00, 8'h1F, 8'h07);
        `CHK("ts_off", 1'b1, sync_request_n_o)
        timestamp_receiver_enable_i <= 1'b1;
        step(3);
        #1 `CHK("ts_on", 1'b0, sync_request_n_o)
        wr(12'h202, 8'h1F);
        #1 `CHK("unsafe", 1'b1, cfg_write_unsafe_o)
        rst_n_i <= 1'b0;
        step(2);
        rst_n_i <= 1'b1;
        link_enable_i <= 1'b0;
        step(2);
        #1 `CHK("unsafe_rst", 1'b0, cfg_write_unsafe_o)
        rd(12'h204, 8'h03);
        rd(12'h20F, 8'h02);
        wr(12'h201, 8'h00);
        #1 `CHK("unsafe_cal", 1'b1, cfg_write_unsafe_o)
        end_sim;
    end
endmodule // tb
